// ### core/acc_pkg.sv
package acc_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] OFS_CONV_B   = 8'h03;
  localparam logic [7:0] OFS_CSR      = 8'h08;
  localparam logic [7:0] OFS_DIDR     = 8'h10;
  localparam logic [7:0] OFS_CONV_A   = 8'h11;
  localparam logic [7:0] OFS_MUX      = 8'h12;
  localparam logic [7:0] OFS_EV_STAT  = 8'h13;
  localparam logic [7:0] OFS_EV_CLR   = 8'h14;
  localparam logic [7:0] OFS_EV_EN    = 8'h15;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int B_NEG_MUX_EN  = 6;
  localparam int B_PWR_OFF     = 7;
  localparam int B_BANDGAP     = 6;
  localparam int B_RESULT      = 5;
  localparam int B_IRQ_FLAG    = 4;
  localparam int B_IRQ_EN      = 3;
  localparam int B_CAPTURE     = 2;
  localparam int B_MODE_HI     = 1;
  localparam int B_MODE_LO     = 0;
  localparam int B_PIN0_OFF    = 0;
  localparam int B_PIN1_OFF    = 1;
  localparam int B_CONV_EN     = 7;
  localparam int CH_W          = 5;
  localparam int N_CH          = 8;
  localparam int N_EV          = 3;

  localparam logic [7:0] CONV_B_WMASK = 8'hD7;
  localparam logic [7:0] RST_BYTE     = 8'h00;
  localparam logic [1:0] SYNC_STAGES  = 2'h2;

  typedef enum logic [1:0] {
    ACC_MODE_TOGGLE  = 2'b00,
    ACC_MODE_RSVD    = 2'b01,
    ACC_MODE_FALL    = 2'b10,
    ACC_MODE_RISE    = 2'b11
  } acc_mode_t;

  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } acc_bus_t;

  typedef struct packed {
    logic [N_CH-1:0] conv_pin;
    logic            pos_pin;
    logic            neg_pin;
    logic            bandgap;
  } acc_analog_t;
endpackage : acc_pkg

// ### core/acc_sync.sv
`timescale 1ns/1ps
`default_nettype none
module acc_sync (
  input  wire logic clk_sys_in,
  input  wire logic rst_b_in,
  input  wire logic async_in,
  output logic      sync_out
);
  import acc_pkg::*;

  typedef struct packed {
    logic meta;
    logic stable;
  } acc_sync_st_t;

  acc_sync_st_t st;
  acc_sync_st_t next_st;

  always_comb begin
    next_st.meta   = async_in;
    next_st.stable = st.meta;
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign sync_out = st.stable;
endmodule // acc_sync
`default_nettype wire

// ### core/acc_edge.sv
`timescale 1ns/1ps
`default_nettype none
module acc_edge (
  input  wire logic             clk_sys_in,
  input  wire logic             rst_b_in,
  input  wire logic             level_in,
  input  wire acc_pkg::acc_mode_t mode_in,
  output logic                  hit_out,
  output logic                  rise_out,
  output logic                  fall_out
);
  import acc_pkg::*;

  typedef struct packed {
    logic prev;
  } acc_edge_st_t;

  acc_edge_st_t st;
  acc_edge_st_t next_st;

  always_comb begin
    next_st.prev = level_in;
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign rise_out = level_in & ~st.prev;
  assign fall_out = ~level_in & st.prev;

  always_comb begin
    unique case (mode_in)
      ACC_MODE_TOGGLE: hit_out = rise_out | fall_out;
      ACC_MODE_RSVD:   hit_out = 1'b0;
      ACC_MODE_FALL:   hit_out = fall_out;
      ACC_MODE_RISE:   hit_out = rise_out;
    endcase
  end
endmodule // acc_edge
`default_nettype wire

// ### core/acc_ctrl.sv
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module acc_ctrl (
  input  wire logic                   clk_sys_in,
  input  wire logic                   rst_b_in,
  input  wire acc_pkg::acc_bus_t      bus_in,
  output logic [acc_pkg::DATA_W-1:0]  rdata_out,
  input  wire acc_pkg::acc_analog_t   analog_in,
  input  wire logic                   global_irq_en_in,
  input  wire logic                   vector_ack_in,
  input  wire logic                   pin0_digital_in,
  input  wire logic                   pin1_digital_in,
  output logic                        pin0_port_out,
  output logic                        pin1_port_out,
  output logic                        cmp_irq_out,
  output logic                        capture_out,
  output logic                        event_irq_out,
  output logic                        cmp_power_off_out,
  output logic                        neg_mux_active_out,
  output logic [acc_pkg::CH_W-1:0]    channel_select_out
);
  import acc_pkg::*;

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [DATA_W-1:0] conv_b;
    logic [DATA_W-1:0] csr;
    logic [DATA_W-1:0] didr;
    logic [DATA_W-1:0] conv_a;
    logic [DATA_W-1:0] mux;
    logic [N_EV-1:0]   ev_stat;
    logic [N_EV-1:0]   ev_en;
    logic [DATA_W-1:0] rdata;
    logic              irq;
    logic              cap;
    logic              ev_irq;
    logic              pwr_off;
    logic              mux_act;
    logic [CH_W-1:0]   chan;
    logic              p0;
    logic              p1;
    logic              raw;
  } acc_st_t;

  acc_st_t st;
  acc_st_t next_st;

  logic      raw_cmp;
  logic      cmp_sync;
  logic      p0_sync;
  logic      p1_sync;
  logic      hit;
  logic      rise;
  logic      fall;
  logic      pos_v;
  logic      neg_v;
  logic      mux_sel;
  acc_mode_t mode;

  function automatic logic is_wr(input acc_bus_t b, input logic [7:0] a);
    return b.wr && (b.addr == a);
  endfunction

  // ****************************************
  // Analog path selection
  // ****************************************
  assign mux_sel = st.conv_b[B_NEG_MUX_EN] & ~st.conv_a[B_CONV_EN];
  assign pos_v   = st.csr[B_BANDGAP] ? analog_in.bandgap
                                     : analog_in.pos_pin;
  always_comb begin
    neg_v = analog_in.neg_pin;
    if (mux_sel && (st.mux[CH_W-1:3] == '0)) begin
      neg_v = analog_in.conv_pin[st.mux[2:0]];
    end
  end
  // Digital model: positive above negative, zero when powered off
  assign raw_cmp = pos_v & ~neg_v & ~st.csr[B_PWR_OFF];
  assign mode    = acc_mode_t'({st.csr[B_MODE_HI], st.csr[B_MODE_LO]});

  acc_sync u_sync_cmp (
    .clk_sys_in (clk_sys_in),
    .rst_b_in   (rst_b_in),
    .async_in   (st.raw),
    .sync_out   (cmp_sync)
  );

  acc_sync u_sync_p0 (
    .clk_sys_in (clk_sys_in),
    .rst_b_in   (rst_b_in),
    .async_in   (pin0_digital_in),
    .sync_out   (p0_sync)
  );

  acc_sync u_sync_p1 (
    .clk_sys_in (clk_sys_in),
    .rst_b_in   (rst_b_in),
    .async_in   (pin1_digital_in),
    .sync_out   (p1_sync)
  );

  acc_edge u_edge (
    .clk_sys_in (clk_sys_in),
    .rst_b_in   (rst_b_in),
    .level_in   (cmp_sync),
    .mode_in    (mode),
    .hit_out    (hit),
    .rise_out   (rise),
    .fall_out   (fall)
  );

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    next_st = st;
    next_st.raw = raw_cmp;
    next_st.csr[B_RESULT] = cmp_sync;

    if (is_wr(bus_in, OFS_CONV_B)) begin
      next_st.conv_b = bus_in.wdata & CONV_B_WMASK;
    end
    if (is_wr(bus_in, OFS_CSR)) begin
      next_st.csr[B_PWR_OFF]  = bus_in.wdata[B_PWR_OFF];
      next_st.csr[B_BANDGAP]  = bus_in.wdata[B_BANDGAP];
      next_st.csr[B_IRQ_EN]   = bus_in.wdata[B_IRQ_EN];
      next_st.csr[B_CAPTURE]  = bus_in.wdata[B_CAPTURE];
      next_st.csr[B_MODE_HI]  = bus_in.wdata[B_MODE_HI];
      next_st.csr[B_MODE_LO]  = bus_in.wdata[B_MODE_LO];
      if (bus_in.wdata[B_IRQ_FLAG]) begin
        next_st.csr[B_IRQ_FLAG] = 1'b0;
      end
    end
    if (vector_ack_in) begin
      next_st.csr[B_IRQ_FLAG] = 1'b0;
    end
    if (hit) begin
      next_st.csr[B_IRQ_FLAG] = 1'b1;
    end
    if (is_wr(bus_in, OFS_DIDR)) begin
      next_st.didr = bus_in.wdata;
    end
    if (is_wr(bus_in, OFS_CONV_A)) begin
      next_st.conv_a = bus_in.wdata;
    end
    if (is_wr(bus_in, OFS_MUX)) begin
      next_st.mux = bus_in.wdata;
    end
    if (is_wr(bus_in, OFS_EV_EN)) begin
      next_st.ev_en = bus_in.wdata[N_EV-1:0];
    end
    if (is_wr(bus_in, OFS_EV_CLR)) begin
      next_st.ev_stat = st.ev_stat & ~bus_in.wdata[N_EV-1:0];
    end
    // Set wins over clear
    next_st.ev_stat = next_st.ev_stat | {hit, fall, rise};

    next_st.rdata = '0;
    if (bus_in.rd) begin
      unique case (bus_in.addr)
        OFS_CONV_B:  next_st.rdata = st.conv_b;
        OFS_CSR:     next_st.rdata = st.csr;
        OFS_DIDR:    next_st.rdata = st.didr;
        OFS_CONV_A:  next_st.rdata = st.conv_a;
        OFS_MUX:     next_st.rdata = st.mux;
        OFS_EV_STAT: next_st.rdata = {{(DATA_W-N_EV){1'b0}}, st.ev_stat};
        OFS_EV_EN:   next_st.rdata = {{(DATA_W-N_EV){1'b0}}, st.ev_en};
        default:     next_st.rdata = '0;
      endcase
    end

    next_st.irq = next_st.csr[B_IRQ_FLAG] & next_st.csr[B_IRQ_EN]
                  & global_irq_en_in;
    next_st.cap = cmp_sync & st.csr[B_CAPTURE];
    next_st.ev_irq  = |(next_st.ev_stat & next_st.ev_en);
    next_st.pwr_off = next_st.csr[B_PWR_OFF];
    next_st.mux_act = mux_sel;
    next_st.chan    = st.mux[CH_W-1:0];
    next_st.p0 = p0_sync & ~st.didr[B_PIN0_OFF];
    next_st.p1 = p1_sync & ~st.didr[B_PIN1_OFF];
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign rdata_out          = st.rdata;
  assign cmp_irq_out        = st.irq;
  assign capture_out        = st.cap;
  assign event_irq_out      = st.ev_irq;
  assign cmp_power_off_out  = st.pwr_off;
  assign neg_mux_active_out = st.mux_act;
  assign channel_select_out = st.chan;
  assign pin0_port_out      = st.p0;
  assign pin1_port_out      = st.p1;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_b_in);

  sequence s_rise_seen;
    (st.csr[B_MODE_HI:B_MODE_LO] == 2'b11) && rise;
  endsequence

  property p_rise_flag;
    s_rise_seen |=> st.csr[B_IRQ_FLAG];
  endproperty
  a_rise_flag: assert property (p_rise_flag) else $error("rise lost");

  property p_rsvd_quiet;
    (mode == ACC_MODE_RSVD) |-> !hit;
  endproperty
  a_rsvd_quiet: assert property (p_rsvd_quiet) else $error("rsvd hit");

  property p_fall_mode;
    (mode == ACC_MODE_FALL) && rise && !fall |-> !hit;
  endproperty
  a_fall_mode: assert property (p_fall_mode) else $error("fall mode");

  property p_ack_clear;
    vector_ack_in && !hit |=> !st.csr[B_IRQ_FLAG];
  endproperty
  a_ack_clear: assert property (p_ack_clear) else $error("ack clr");

  property p_irq_gate;
    cmp_irq_out |-> $past(global_irq_en_in) && st.csr[B_IRQ_EN];
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq gate");

  property p_sync_lat;
    $rose(st.raw) ##1 st.raw |=> ##1 st.csr[B_RESULT];
  endproperty
  a_sync_lat: assert property (p_sync_lat) else $error("sync lat");

  property p_off_low;
    st.csr[B_PWR_OFF] |=> !st.raw;
  endproperty
  a_off_low: assert property (p_off_low) else $error("pwr off");

  property p_didr_zero;
    st.didr[B_PIN0_OFF] |=> !pin0_port_out;
  endproperty
  a_didr_zero: assert property (p_didr_zero) else $error("didr");

  property p_cap_off;
    !st.csr[B_CAPTURE] |=> !capture_out;
  endproperty
  a_cap_off: assert property (p_cap_off) else $error("capture");

  property p_mux_gate;
    st.conv_a[B_CONV_EN] |=> !neg_mux_active_out;
  endproperty
  a_mux_gate: assert property (p_mux_gate) else $error("mux gate");

  // ****************************************
  // Event, flag and output checks
  // ****************************************
  sequence s_fall_seen;
    (mode == ACC_MODE_FALL) && fall;
  endsequence

  sequence s_any_edge;
    (mode == ACC_MODE_TOGGLE) && (rise || fall);
  endsequence

  property p_fall_flag;
    s_fall_seen |=> st.csr[B_IRQ_FLAG];
  endproperty
  a_fall_flag: assert property (p_fall_flag) else $error("fall lost");

  property p_toggle_flag;
    s_any_edge |=> st.csr[B_IRQ_FLAG];
  endproperty
  a_toggle_flag: assert property (p_toggle_flag) else $error("toggle");

  property p_rise_mode;
    (mode == ACC_MODE_RISE) && fall && !rise |-> !hit;
  endproperty
  a_rise_mode: assert property (p_rise_mode) else $error("rise mode");

  property p_wclr_flag;
    bus_in.wr && (bus_in.addr == OFS_CSR) && bus_in.wdata[B_IRQ_FLAG]
      && !hit |=> !st.csr[B_IRQ_FLAG];
  endproperty
  a_wclr_flag: assert property (p_wclr_flag) else $error("w1c flag");

  property p_flag_hold;
    st.csr[B_IRQ_FLAG] && !vector_ack_in
      && !(bus_in.wr && (bus_in.addr == OFS_CSR)) |=> st.csr[B_IRQ_FLAG];
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag hold");

  property p_irq_flag;
    cmp_irq_out |-> st.csr[B_IRQ_FLAG];
  endproperty
  a_irq_flag: assert property (p_irq_flag) else $error("irq flag");

  property p_irq_en_off;
    !st.csr[B_IRQ_EN] |-> !cmp_irq_out;
  endproperty
  a_irq_en_off: assert property (p_irq_en_off) else $error("irq en");

  property p_irq_on;
    st.csr[B_IRQ_FLAG] && st.csr[B_IRQ_EN] && $past(global_irq_en_in)
      |-> cmp_irq_out;
  endproperty
  a_irq_on: assert property (p_irq_on) else $error("irq on");

  property p_cap_on;
    st.csr[B_CAPTURE] && cmp_sync |=> capture_out;
  endproperty
  a_cap_on: assert property (p_cap_on) else $error("capture on");

  property p_mux_on;
    mux_sel |=> neg_mux_active_out;
  endproperty
  a_mux_on: assert property (p_mux_on) else $error("mux on");

  property p_result_follow;
    1'b1 |=> (st.csr[B_RESULT] == $past(cmp_sync));
  endproperty
  a_result_follow: assert property (p_result_follow) else $error("result");

  property p_rdata_idle;
    !bus_in.rd |=> (rdata_out == '0);
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("rdata idle");

  property p_pin1_zero;
    st.didr[B_PIN1_OFF] |=> !pin1_port_out;
  endproperty
  a_pin1_zero: assert property (p_pin1_zero) else $error("didr pin1");

  property p_off_raw;
    st.csr[B_PWR_OFF] |-> !raw_cmp;
  endproperty
  a_off_raw: assert property (p_off_raw) else $error("pwr raw");

  property p_ev_clr;
    bus_in.wr && (bus_in.addr == OFS_EV_CLR) && bus_in.wdata[0] && !rise
      |=> !st.ev_stat[0];
  endproperty
  a_ev_clr: assert property (p_ev_clr) else $error("event clear");
endmodule // acc_ctrl
`default_nettype wire

// ### tb/acc_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
module acc_pin_model #(
  parameter logic BG_LEVEL = 1'b1
) (
  input  wire logic                  pos_lvl_in,
  input  wire logic                  neg_lvl_in,
  input  wire logic [7:0]            conv_lvl_in,
  output var  acc_pkg::acc_analog_t  analog_out,
  output logic                       pin0_out,
  output logic                       pin1_out
);
  import acc_pkg::*;
  // ********************
  // Pin levels
  // ********************
  // Bandgap is a fixed reference, never follows the pins
  assign analog_out = '{conv_pin: conv_lvl_in, pos_pin: pos_lvl_in,
                        neg_pin: neg_lvl_in, bandgap: BG_LEVEL};
  // Comparator pins double as digital port pins
  assign pin0_out = pos_lvl_in;
  assign pin1_out = neg_lvl_in;
endmodule // acc_pin_model
`default_nettype wire

// ### tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import acc_pkg::*;
  logic        clk_sys_in = 1'b0;
  logic        rst_b_in   = 1'b0;
  acc_bus_t    bus        = '0;
  logic        pos        = 1'b0;
  logic        neg        = 1'b0;
  logic        glob       = 1'b0;
  logic        vack       = 1'b0;
  logic [7:0]  conv       = 8'h00;
  logic [7:0]  rdata_out;
  acc_analog_t ana;
  logic        p0, p1, irq, cap, evi, pwr, mux, o0, o1;
  logic [4:0]  ch;
  int          errors     = 0;
  int          n_tests    = 0;
  int          cyc        = 0;
  wire logic [15:0] outs = {3'h0, ch, irq, cap, evi, pwr, mux, o0, o1, 1'b0};

  always #20 clk_sys_in = ~clk_sys_in;

  acc_pin_model u_pins (.pos_lvl_in(pos), .neg_lvl_in(neg),
    .conv_lvl_in(conv), .analog_out(ana), .pin0_out(p0), .pin1_out(p1));
  acc_ctrl dut (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .bus_in(bus),
    .rdata_out(rdata_out), .analog_in(ana), .global_irq_en_in(glob),
    .vector_ack_in(vack), .pin0_digital_in(p0), .pin1_digital_in(p1),
    .pin0_port_out(o0), .pin1_port_out(o1), .cmp_irq_out(irq),
    .capture_out(cap), .event_irq_out(evi), .cmp_power_off_out(pwr),
    .neg_mux_active_out(mux), .channel_select_out(ch));

  // ********************
  // Access tasks
  // ********************
  task automatic chk(input string nm, input logic [15:0] e, g);
    n_tests++;
    if (g !== e) begin
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
      errors++;
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    bus.wr <= 1'b1;
    bus.addr <= a;
    bus.wdata <= d;
    @(posedge clk_sys_in);
    bus.wr <= 1'b0;
    @(posedge clk_sys_in);
  endtask
  task automatic rd(input string nm, input logic [7:0] a, e);
    logic [7:0] d;
    bus.rd <= 1'b1;
    bus.addr <= a;
    @(posedge clk_sys_in);
    bus.rd <= 1'b0;
    #20;
    d = rdata_out;
    @(posedge clk_sys_in);
    chk(nm, {8'h00, e}, {8'h00, d});
  endtask
  task automatic oc(input string nm, input logic [15:0] m, e);
    @(negedge clk_sys_in);
    chk(nm, e, outs & m);
    @(posedge clk_sys_in);
  endtask
  task automatic settle;
    repeat (6) @(posedge clk_sys_in);
  endtask
  task automatic finish_test;
    $display("errors %0d checks %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  always @(posedge clk_sys_in) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      errors++;
      finish_test();
    end
  end

  // ********************
  // Scenarios
  // ********************
  initial begin
    repeat (5) @(posedge clk_sys_in);
    rst_b_in <= 1'b1;
    @(posedge clk_sys_in);
    rd("csr_rst", OFS_CSR, 8'h00);
    rd("convb_rst", OFS_CONV_B, 8'h00);
    rd("didr_rst", OFS_DIDR, 8'h00);
    oc("outs_rst", 16'h00F0, 16'h0000);
    rd("unmapped", 8'h40, 8'h00);
    wr(OFS_CSR, 8'h01);
    pos <= 1'b1;
    rd("csr_early", OFS_CSR, 8'h01);
    settle();
    rd("csr_hi", OFS_CSR, 8'h21);
    neg <= 1'b1;
    settle();
    rd("csr_eq", OFS_CSR, 8'h01);
    wr(OFS_CONV_B, 8'hFF);
    rd("convb_mask", OFS_CONV_B, CONV_B_WMASK);
    for (int c = 0; c < 9; c++) begin
      conv <= ~(8'h01 << c);
      wr(OFS_MUX, c[7:0]);
      settle();
      rd("csr_mux", OFS_CSR, (c < 8) ? 8'h21 : 8'h01);
      oc("mux_out", 16'h1F08, {3'h0, c[4:0], 8'h08});
    end
    wr(OFS_MUX, 8'h00);
    conv <= 8'hFE;
    wr(OFS_CONV_A, 8'h80);
    settle();
    rd("csr_conv_on", OFS_CSR, 8'h01);
    oc("mux_off", 16'h0008, 16'h0000);
    wr(OFS_CONV_A, 8'h00);
    settle();
    rd("csr_conv_off", OFS_CSR, 8'h21);
    wr(OFS_CONV_B, 8'h00);
    settle();
    rd("csr_mux_dis", OFS_CSR, 8'h01);
    pos <= 1'b0;
    neg <= 1'b0;
    wr(OFS_CSR, 8'h41);
    settle();
    rd("csr_bg", OFS_CSR, 8'h61);
    wr(OFS_CSR, 8'h01);
    settle();
    rd("csr_nobg", OFS_CSR, 8'h01);
    pos <= 1'b1;
    neg <= 1'b1;
    settle();
    oc("pins_on", 16'h0006, 16'h0006);
    wr(OFS_DIDR, 8'h01);
    oc("pin0_off", 16'h0006, 16'h0002);
    wr(OFS_DIDR, 8'h02);
    oc("pin1_off", 16'h0006, 16'h0004);
    rd("didr", OFS_DIDR, 8'h02);
    wr(OFS_DIDR, 8'h00);
    neg <= 1'b0;
    wr(OFS_CSR, 8'h05);
    settle();
    oc("cap_on", 16'h0040, 16'h0040);
    wr(OFS_CSR, 8'h01);
    oc("cap_off", 16'h0040, 16'h0000);
    wr(OFS_CSR, 8'h83);
    settle();
    rd("csr_off", OFS_CSR, 8'h83);
    oc("pwr_out", 16'h0010, 16'h0010);
    wr(OFS_CSR, 8'h13);
    settle();
    rd("csr_pwr_on", OFS_CSR, 8'h33);
    pos <= 1'b0;
    settle();
    for (int m = 0; m < 4; m++) begin
      wr(OFS_CSR, {6'h04, m[1:0]});
      pos <= 1'b1;
      settle();
      rd("flag_rise", OFS_CSR, {3'h1, m == 0 || m == 3, 2'h0, m[1:0]});
      wr(OFS_CSR, {6'h04, m[1:0]});
      pos <= 1'b0;
      settle();
      rd("flag_fall", OFS_CSR, {3'h0, m == 0 || m == 2, 2'h0, m[1:0]});
    end
    glob <= 1'b1;
    pos <= 1'b1;
    settle();
    oc("irq_dis", 16'h0080, 16'h0000);
    wr(OFS_CSR, 8'h0B);
    oc("irq_on", 16'h0080, 16'h0080);
    glob <= 1'b0;
    @(posedge clk_sys_in);
    oc("irq_glob", 16'h0080, 16'h0000);
    glob <= 1'b1;
    vack <= 1'b1;
    @(posedge clk_sys_in);
    vack <= 1'b0;
    @(posedge clk_sys_in);
    oc("irq_ack", 16'h0080, 16'h0000);
    rd("flag_ack", OFS_CSR, 8'h2B);
    wr(OFS_CSR, 8'h03);
    pos <= 1'b0;
    settle();
    wr(OFS_EV_CLR, 8'h07);
    wr(OFS_EV_EN, 8'h01);
    pos <= 1'b1;
    settle();
    rd("ev_stat", OFS_EV_STAT, 8'h05);
    oc("ev_irq", 16'h0020, 16'h0020);
    wr(OFS_EV_EN, 8'h00);
    oc("ev_mask", 16'h0020, 16'h0000);
    wr(OFS_EV_CLR, 8'h01);
    wr(OFS_EV_STAT, 8'hFF);
    rd("ev_clr", OFS_EV_STAT, 8'h04);
    finish_test();
  end
endmodule // testbench
`default_nettype wire
